// >>> hdl/tsi_top.sv
// two-wire serial slave with word memory, modulator modes and reset handling
`timescale 1ns/100ps
`include "tsi_cfg.svh"
module tsi_top (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// two-wire link, sda open drain
	input wire logic scl,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_n,
	// two-way reset pin
	input wire logic bidir_reset_pin_in,
	output logic bidir_reset_pin_out,
	output logic bidir_reset_pin_oe_n,
	// modulator stage
	output logic mod_active,
	output logic mod_manchester,
	output logic mod_clk,
	output logic mod_data,
	output logic mod_strobe,
	// power management
	output logic pm_auto
);
	import tsi_pkg::*;

	function automatic logic [7:0] pick_byte(input logic [15:0] w, input logic upper);
		pick_byte = upper ? w[15:8] : w[7:0];
	endfunction : pick_byte

	// mode bit set means decrement, else increment; 5 bits wrap by themselves
	function automatic tsi_row_t step_row(input tsi_row_t r, input logic dec);
		step_row = dec ? r - 5'h01 : r + 5'h01;
	endfunction : step_row

	logic [15:0] mem [0:31];
	logic [2:0] syn_q;
	logic scl_q, sda_q, rstpin_q, scl_d, sda_d;
	logic scl_rise, scl_fall, start_cond, stop_cond;
	tsi_state_t state;
	logic [3:0] bitcnt;
	logic [7:0] sh, out_sh;
	logic [15:0] word_buf, cur_word, nxt_word;
	tsi_row_t row_addr, next_row, mem_idx;
	logic hi_first, second, got_ack, special;
	logic ctrl_done, is_spec, is_read;
	logic [7:0] byte_a, byte_b, byte_c;
	logic field_present, supply_field, fb_switch, sif_rst;
	logic acc_wr, acc_rd;
	logic [31:0] rd_mux;
	logic rd_hit;

	tsi_sync #(.W(3)) u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.d({bidir_reset_pin_in, sda_in, scl}),
		.q(syn_q)
	);
	assign scl_q = syn_q[0];
	assign sda_q = syn_q[1];
	assign rstpin_q = syn_q[2];

	tsi_rst u_rst (
		.pclk(pclk),
		.presetn(presetn),
		.trig(fb_switch),
		.pin_out(bidir_reset_pin_out),
		.pin_oe_n(bidir_reset_pin_oe_n)
	);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			scl_d <= 1'b1;
			sda_d <= 1'b1;
		end else begin
			scl_d <= scl_q;
			sda_d <= sda_q;
		end
	end

	always_comb begin
		scl_rise = scl_q & ~scl_d;
		scl_fall = ~scl_q & scl_d;
		start_cond = scl_q & scl_d & sda_d & ~sda_q;
		stop_cond = scl_q & scl_d & ~sda_d & sda_q;
		ctrl_done = (state == ST_CTRL) && scl_fall && (bitcnt == 4'h8);
		is_spec = (sh[7:6] == 2'b11) && (sh[2:0] == 3'b111);
		is_read = sh[0] && !is_spec;
		cur_word = mem[row_addr];
		next_row = step_row(row_addr, hi_first);
		nxt_word = mem[next_row];
		byte_a = pick_byte(cur_word, hi_first);
		byte_b = pick_byte(word_buf, ~hi_first);
		byte_c = pick_byte(nxt_word, hi_first);
	end

	// supply tracking: leaving field supply resets the interface and the host
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			supply_field <= 1'b0;
			fb_switch <= 1'b0;
			sif_rst <= 1'b0;
		end else begin
			supply_field <= field_present & pm_auto;
			fb_switch <= supply_field & ~(field_present & pm_auto);
			sif_rst <= ~rstpin_q | fb_switch;
		end
	end

	// serial state machine; starts are ignored while streaming to the modulator
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= ST_IDLE;
			bitcnt <= 4'h0;
			sh <= 8'h00;
			out_sh <= 8'h00;
			word_buf <= 16'h0000;
			row_addr <= `TSI_ROW_RST;
			hi_first <= 1'b0;
			second <= 1'b0;
			got_ack <= 1'b0;
			special <= 1'b0;
			sda_oe_n <= 1'b1;
		end else if (sif_rst || stop_cond) begin
			state <= ST_IDLE;
			sda_oe_n <= 1'b1;
			special <= 1'b0;
			if (sif_rst) begin
				row_addr <= `TSI_ROW_RST;
			end
		end else if (start_cond && state != ST_MOD) begin
			state <= ST_CTRL;
			bitcnt <= 4'h0;
			sda_oe_n <= 1'b1;
		end else begin
			case (state)
				ST_CTRL: begin
					if (scl_rise) begin
						sh <= {sh[6:0], sda_q};
						bitcnt <= bitcnt + 4'h1;
					end
					if (ctrl_done) begin
						if (is_spec || is_read) begin
							sda_oe_n <= 1'b0;
							state <= ST_CACK;
							special <= is_spec;
							hi_first <= sh[2];
							// mode 00 reads from the current pointer
							if (is_read && sh[2:1] != 2'b00) begin
								row_addr <= sh[7:3];
							end
						end else begin
							state <= ST_WAIT;
						end
					end
				end
				ST_CACK: begin
					if (scl_fall) begin
						if (special) begin
							sda_oe_n <= 1'b1;
							state <= ST_MOD;
						end else begin
							word_buf <= cur_word;
							out_sh <= byte_a;
							sda_oe_n <= byte_a[7];
							second <= 1'b0;
							bitcnt <= 4'h0;
							state <= ST_SEND;
						end
					end
				end
				ST_SEND: begin
					if (scl_fall) begin
						bitcnt <= bitcnt + 4'h1;
						if (bitcnt == 4'h7) begin
							sda_oe_n <= 1'b1;
							state <= ST_MACK;
						end else begin
							out_sh <= {out_sh[6:0], 1'b0};
							sda_oe_n <= out_sh[6];
						end
					end
				end
				ST_MACK: begin
					if (scl_rise) begin
						got_ack <= ~sda_q;
					end
					if (scl_fall) begin
						if (got_ack) begin
							bitcnt <= 4'h0;
							state <= ST_SEND;
							if (second) begin
								row_addr <= next_row;
								word_buf <= nxt_word;
								out_sh <= byte_c;
								sda_oe_n <= byte_c[7];
								second <= 1'b0;
							end else begin
								out_sh <= byte_b;
								sda_oe_n <= byte_b[7];
								second <= 1'b1;
							end
						end else begin
							// both bytes sent: step even on no-ack so a current-address read follows on
							if (second) begin
								row_addr <= next_row;
							end
							state <= ST_WAIT;
						end
					end
				end
				ST_IDLE, ST_WAIT, ST_MOD: begin
					state <= state;
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	// modulator mode and power management flags
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mod_active <= 1'b0;
			mod_manchester <= 1'b0;
			pm_auto <= `TSI_PM_AUTO_RST;
		end else if (sif_rst) begin
			mod_active <= 1'b0;
			mod_manchester <= 1'b0;
			pm_auto <= `TSI_PM_AUTO_RST;
		end else begin
			if (stop_cond) begin
				mod_active <= 1'b0;
			end else if (state == ST_CACK && scl_fall && special) begin
				mod_active <= 1'b1;
			end
			if (ctrl_done && is_spec) begin
				mod_manchester <= sh[4];
				pm_auto <= sh[3];
			end
		end
	end

	// modulator stream: no acknowledge slots, every rising clock takes a bit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mod_clk <= 1'b0;
			mod_data <= 1'b0;
			mod_strobe <= 1'b0;
			sda_out <= 1'b0;
		end else begin
			sda_out <= 1'b0;
			mod_clk <= (state == ST_MOD) & scl_q;
			mod_strobe <= (state == ST_MOD) & scl_rise;
			if (state == ST_MOD && scl_rise) begin
				mod_data <= sda_q;
			end
		end
	end

	// apb slave, one wait-free access phase
	assign acc_wr = psel & penable & pwrite & pready;
	assign acc_rd = psel & ~penable;

	always_comb begin
		rd_mux = 32'h0000_0000;
		rd_hit = 1'b1;
		case (paddr)
			`TSI_REG_CTRL: rd_mux[`TSI_CTRL_FIELD] = field_present;
			`TSI_REG_STATUS: begin
				rd_mux[`TSI_ST_MOD_ACT] = mod_active;
				rd_mux[`TSI_ST_MANCH] = mod_manchester;
				rd_mux[`TSI_ST_PM_AUTO] = pm_auto;
				rd_mux[`TSI_ST_SUP_FIELD] = supply_field;
				rd_mux[`TSI_ST_ROW_LSB +: 5] = row_addr;
				rd_mux[`TSI_ST_STATE_LSB +: 3] = state;
			end
			`TSI_REG_MEM_IDX: rd_mux[4:0] = mem_idx;
			`TSI_REG_MEM_DATA: rd_mux[15:0] = mem[mem_idx];
			default: rd_hit = 1'b0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			pready <= psel & ~penable & ~pready;
			if (acc_rd) begin
				prdata <= pwrite ? 32'h0000_0000 : rd_mux;
				pslverr <= ~rd_hit;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			field_present <= `TSI_FIELD_RST;
			mem_idx <= 5'h00;
		end else if (acc_wr) begin
			if (paddr == `TSI_REG_CTRL) begin
				field_present <= pwdata[`TSI_CTRL_FIELD];
			end
			if (paddr == `TSI_REG_MEM_IDX) begin
				mem_idx <= pwdata[4:0];
			end
		end
	end

	// memory contents are loaded by software; no reset on the array
	always_ff @(posedge pclk) begin
		if (acc_wr && paddr == `TSI_REG_MEM_DATA) begin
			mem[mem_idx] <= pwdata[15:0];
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_read_ack;
		ctrl_done && is_read && !sif_rst && !stop_cond |-> ##1 (state == ST_CACK) && !sda_oe_n;
	endproperty
	a_read_ack: assert property (p_read_ack) else $error("read control byte not acknowledged");

	property p_stop_idle;
		stop_cond |-> ##1 (state == ST_IDLE) && !mod_active && sda_oe_n;
	endproperty
	a_stop_idle: assert property (p_stop_idle) else $error("stop did not end the transfer");

	property p_mod_hold;
		(state == ST_MOD) && start_cond && !stop_cond && !sif_rst |-> ##1 (state == ST_MOD);
	endproperty
	a_mod_hold: assert property (p_mod_hold) else $error("start decoded in modulator mode");

	property p_row_step;
		(state == ST_MACK) && scl_fall && got_ack && second && !sif_rst && !stop_cond && !start_cond
			|-> ##1 row_addr == 5'($past(row_addr) + ($past(hi_first) ? 5'h1f : 5'h01));
	endproperty
	a_row_step: assert property (p_row_step) else $error("row address not stepped");

	property p_order;
		(state == ST_CACK) && scl_fall && !special && !sif_rst && !stop_cond && !start_cond
			|-> ##1 out_sh == (hi_first ? word_buf[15:8] : word_buf[7:0]);
	endproperty
	a_order: assert property (p_order) else $error("wrong first byte");

	property p_mod_sample;
		(state == ST_MOD) && scl_rise && !sif_rst && !stop_cond |-> ##1 mod_strobe && (mod_data == $past(sda_q));
	endproperty
	a_mod_sample: assert property (p_mod_sample) else $error("modulator bit not taken");

	property p_rst_pin;
		fb_switch |-> ##1 !bidir_reset_pin_oe_n [*8];
	endproperty
	a_rst_pin: assert property (p_rst_pin) else $error("reset pin not driven");

	property p_pin_reset;
		!rstpin_q |-> ##1 sif_rst ##1 (state == ST_IDLE) && (row_addr == `TSI_ROW_RST);
	endproperty
	a_pin_reset: assert property (p_pin_reset) else $error("reset pin did not reset interface");

	property p_pm;
		ctrl_done && is_spec && !sif_rst |-> ##1 (pm_auto == $past(sh[3])) && (mod_manchester == $past(sh[4]));
	endproperty
	a_pm: assert property (p_pm) else $error("special byte not applied");

	c_word_read: cover property ((state == ST_MACK) && scl_fall && got_ack && second);
	c_mod_bits: cover property ((state == ST_MOD) && mod_strobe);
	c_nack_end: cover property ((state == ST_MACK) && scl_fall && !got_ack);
	c_fb_switch: cover property (fb_switch);
endmodule : tsi_top

// >>> hdl/tsi_cfg.svh
// register map, field positions, reset values and timing counts of the transponder serial interface
`ifndef TSI_CFG_SVH
`define TSI_CFG_SVH

`define TSI_CLK_MHZ 125
`define TSI_RST_PULSE_NS 10000
`define TSI_RST_PULSE_CYC ((`TSI_RST_PULSE_NS * `TSI_CLK_MHZ) / 1000)
`define TSI_RST_CNT_W 11

`define TSI_REG_CTRL 8'h00
`define TSI_REG_STATUS 8'h04
`define TSI_REG_MEM_IDX 8'h08
`define TSI_REG_MEM_DATA 8'h0c

`define TSI_CTRL_FIELD 0
`define TSI_ST_MOD_ACT 0
`define TSI_ST_MANCH 1
`define TSI_ST_PM_AUTO 2
`define TSI_ST_SUP_FIELD 3
`define TSI_ST_ROW_LSB 8
`define TSI_ST_STATE_LSB 16

`define TSI_PM_AUTO_RST 1'b1
`define TSI_FIELD_RST 1'b0
`define TSI_ROW_RST 5'h00

`endif

// >>> hdl/tsi_pkg.sv
// types shared by the transponder serial interface
package tsi_pkg;
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_CTRL = 3'h1,
		ST_CACK = 3'h3,
		ST_SEND = 3'h2,
		ST_MACK = 3'h6,
		ST_MOD = 3'h7,
		ST_WAIT = 3'h5
	} tsi_state_t;
	typedef logic [4:0] tsi_row_t;
endpackage : tsi_pkg

// >>> hdl/tsi_sync.sv
// two-flop synchroniser for pins from outside the pclk domain
`timescale 1ns/100ps
module tsi_sync #(
	parameter int W = 3
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// pins and their synchronised copy
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta <= '1;
			q <= '1;
		end else begin
			meta <= d;
			q <= meta;
		end
	end
endmodule : tsi_sync

// >>> hdl/tsi_rst.sv
// reset-pin driver: pulls the two-way reset pin low for a fixed time
`timescale 1ns/100ps
`include "tsi_cfg.svh"
module tsi_rst (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// request
	input wire logic trig,
	// pin driver, oe_n low while driving
	output logic pin_out,
	output logic pin_oe_n
);
	logic [`TSI_RST_CNT_W-1:0] cnt;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= '0;
			pin_oe_n <= 1'b1;
			pin_out <= 1'b0;
		end else begin
			pin_out <= 1'b0;
			if (trig) begin
				// a new switch-over restarts the pulse
				cnt <= `TSI_RST_CNT_W'(`TSI_RST_PULSE_CYC);
				pin_oe_n <= 1'b0;
			end else if (cnt > `TSI_RST_CNT_W'(1)) begin
				cnt <= cnt - `TSI_RST_CNT_W'(1);
			end else begin
				cnt <= '0;
				pin_oe_n <= 1'b1;
			end
		end
	end
endmodule : tsi_rst

// >>> dv/tsi_master.sv
// two-wire bus master model driving the link as the host would
`timescale 1ns/100ps
module tsi_master (
	// clock
	input wire logic pclk,
	// resolved data line
	input wire logic sda,
	// link drive, sda_m high releases the line to its pull-up
	output logic scl,
	output logic sda_m
);
	initial begin
		scl = 1'b1;
		sda_m = 1'b1;
	end
	// half of a 160 ns link period; scl stands high between frames
	task automatic half();
		repeat (10) @(posedge pclk);
	endtask : half
	task automatic start();
		sda_m <= 1'b1;
		half();
		scl <= 1'b1;
		half();
		sda_m <= 1'b0;
		half();
		scl <= 1'b0;
		repeat (2) @(posedge pclk);
	endtask : start
	task automatic stop();
		sda_m <= 1'b0;
		half();
		scl <= 1'b1;
		half();
		sda_m <= 1'b1;
		half();
	endtask : stop
	// data moves two pclk clear of the scl fall so the synchronised pair never shows a false start
	task automatic bit_io(input logic b, output logic r);
		sda_m <= b;
		half();
		scl <= 1'b1;
		half();
		r = sda;
		scl <= 1'b0;
		repeat (2) @(posedge pclk);
	endtask : bit_io
	task automatic wr_byte(input logic [7:0] b, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			bit_io(b[i], ack);
		end
		bit_io(1'b1, ack);
	endtask : wr_byte
	task automatic rd_byte(input logic nack, output logic [7:0] b);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, r);
			b[i] = r;
		end
		bit_io(nack, r);
	endtask : rd_byte
endmodule : tsi_master

// >>> dv/tsi_top_tb.sv
// self-checking bench for the transponder serial interface
`timescale 1ns/100ps
`include "tsi_cfg.svh"
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin n_errors++; $display("Error t=%0t got %h exp %h", $time, got, exp); end end
module tsi_top_tb;
	import tsi_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, d;
	logic scl, sda, sda_m, sda_out, sda_oe_n, rst_m, bidir_reset_pin_in, rpin_out, rpin_oe_n;
	logic mod_active, mod_manchester, mod_clk, mod_data, mod_strobe, pm_auto, e;
	logic [8:0] cap;
	logic [3:0] ncap;
	int n_errors = 0;
	int tests_run = 0;
	int len;
	localparam logic [8:0] PAT = 9'h16b;
	// open-drain wires with pull-ups
	assign sda = sda_m & (sda_oe_n | sda_out);
	assign bidir_reset_pin_in = rst_m & (rpin_oe_n | rpin_out);
	always #4 pclk = ~pclk;
	always @(posedge pclk) begin
		if (mod_strobe === 1'b1) begin
			cap <= {cap[7:0], mod_data};
			ncap <= ncap + 4'h1;
		end
	end
	tsi_top u_tsi_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .scl(scl),
		.sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .bidir_reset_pin_in(bidir_reset_pin_in),
		.bidir_reset_pin_out(rpin_out), .bidir_reset_pin_oe_n(rpin_oe_n), .mod_active(mod_active),
		.mod_manchester(mod_manchester), .mod_clk(mod_clk), .mod_data(mod_data), .mod_strobe(mod_strobe),
		.pm_auto(pm_auto));
	tsi_master u_tsi_master (.pclk(pclk), .sda(sda), .scl(scl), .sda_m(sda_m));
	task automatic results();
		$display("checks %0d errors %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : results
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd,
		output logic err);
		int n;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			n_errors++;
			results();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// one idle edge so a following call never reassigns psel in this time step
		@(posedge pclk);
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [31:0] wd);
		apb(1'b1, a, wd, d, e);
	endtask : wr
	task automatic chk_rd(input logic [7:0] a, input logic [31:0] exp, input logic eerr);
		apb(1'b0, a, 32'h0, d, e);
		`CHK(d, exp)
		`CHK(e, eerr)
	endtask : chk_rd
	task automatic ser_rd(input logic [7:0] ctl, input int n, input logic [31:0] exp, input logic eack);
		logic ack;
		logic [7:0] b;
		u_tsi_master.start();
		u_tsi_master.wr_byte(ctl, ack);
		`CHK(ack, eack)
		for (int i = 0; i < n; i++) begin
			u_tsi_master.rd_byte(i == n - 1, b);
			`CHK(b, exp[31 - 8 * i -: 8])
		end
		if (n > 0) u_tsi_master.stop();
	endtask : ser_rd
	task automatic modul(input logic [7:0] ctl, input logic eman, input logic epm);
		logic [8:0] line;
		ser_rd(ctl, 0, 32'h0, 1'b0);
		repeat (4) @(posedge pclk);
		`CHK({mod_active, mod_manchester, pm_auto}, {1'b1, eman, epm})
		ncap <= 4'h0;
		for (int i = 8; i >= 0; i--) begin
			u_tsi_master.bit_io(PAT[i], line[i]);
		end
		repeat (6) @(posedge pclk);
		`CHK({ncap, cap}, {4'h9, PAT})
		`CHK(line, PAT)
		u_tsi_master.stop();
		repeat (6) @(posedge pclk);
		`CHK(mod_active, 1'b0)
	endtask : modul
	task automatic pulse_len(output int l);
		int w;
		l = 0;
		w = 0;
		while (rpin_oe_n !== 1'b0 && w < 20) begin
			@(posedge pclk);
			w++;
		end
		while (rpin_oe_n === 1'b0 && l < 2000) begin
			@(posedge pclk);
			l++;
		end
	endtask : pulse_len
	initial begin
		repeat (100000) @(posedge pclk);
		n_errors++;
		results();
	end
	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		rst_m = 1'b1;
		ncap = 4'h0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		repeat (3) @(posedge pclk);
		chk_rd(`TSI_REG_STATUS, 32'h4, 1'b0);
		chk_rd(`TSI_REG_CTRL, 32'h0, 1'b0);
		chk_rd(8'h10, 32'h0, 1'b1);
		for (int r = 0; r < 32; r++) begin
			wr(`TSI_REG_MEM_IDX, 32'(r));
			wr(`TSI_REG_MEM_DATA, {16'h0, 8'h80 | 8'(r), 8'h40 | 8'(r)});
		end
		chk_rd(`TSI_REG_MEM_DATA, 32'h9f5f, 1'b0);
		ser_rd(8'hfb, 4, 32'h5f9f4080, 1'b0);
		ser_rd(8'h05, 4, 32'h80409f5f, 1'b0);
		ser_rd(8'h01, 1, 32'h5e000000, 1'b0);
		for (int i = 0; i < 2; i++) begin
			ser_rd(i ? 8'hce : 8'hfa, 0, 32'h0, 1'b1);
			u_tsi_master.stop();
		end
		modul(8'hc7, 1'b0, 1'b0);
		modul(8'hdf, 1'b1, 1'b1);
		wr(`TSI_REG_CTRL, 32'h1);
		apb(1'b0, `TSI_REG_STATUS, 32'h0, d, e);
		`CHK(d[3:0], 4'he)
		wr(`TSI_REG_CTRL, 32'h0);
		pulse_len(len);
		`CHK(len, `TSI_RST_PULSE_CYC)
		repeat (6) @(posedge pclk);
		chk_rd(`TSI_REG_STATUS, 32'h4, 1'b0);
		ser_rd(8'hc7, 0, 32'h0, 1'b0);
		u_tsi_master.stop();
		ser_rd(8'h2b, 1, 32'h45000000, 1'b0);
		rst_m <= 1'b0;
		repeat (4) @(posedge pclk);
		rst_m <= 1'b1;
		repeat (6) @(posedge pclk);
		chk_rd(`TSI_REG_STATUS, 32'h4, 1'b0);
		results();
	end
endmodule : tsi_top_tb
